/* File: core/snv_regs.vh */
// constants for the sensor configuration target: commands, register
// addresses, field positions, reset words and timing counts
// assumes the includer runs on a 200 MHz clock
`ifndef SNV_REGS_VH
`define SNV_REGS_VH

// command bytes that open or close programming mode
`define SNV_CMD_PROG_ENTER 8'hA0
`define SNV_CMD_PROG_LEAVE 8'h80

// sixteen-bit configuration register addresses
`define SNV_ADDR_HUM_RD 8'h06
`define SNV_ADDR_TEMP_RD 8'h11
`define SNV_ADDR_ID_HI 8'h1E
`define SNV_ADDR_ID_LO 8'h1F
`define SNV_ADDR_HUM_WR 8'h46
`define SNV_ADDR_TEMP_WR 8'h51

// resolution field inside each resolution word
`define SNV_RES_MSB 11
`define SNV_RES_LSB 10
`define SNV_RES_8BIT 2'h0
`define SNV_RES_10BIT 2'h1
`define SNV_RES_12BIT 2'h2
`define SNV_RES_14BIT 2'h3

// reset word of each resolution register: 14-bit setting
`define SNV_RES_WORD_INIT 16'h0C00

// status byte returned ahead of register contents
`define SNV_STATUS_OK 8'h81

// measurement status bits in the first byte
`define SNV_MEAS_FRESH 2'h0
`define SNV_MEAS_STALE 2'h1

// timing: figures as printed and derived cycle counts
`define SNV_CLK_MHZ 200
`define SNV_LOAD_US 120
`define SNV_COMMIT_MS 14
// cycle counts sized to the 22-bit timers: 120 us and 14 ms at 200 MHz
`define SNV_LOAD_CYC 22'h005DC0
`define SNV_COMMIT_CYC 22'h2AB980

`endif

/* File: core/snv_nvm_store.v */
// configuration word store: resolution words, identity number, and the
// load and commit timers that keep the store busy after each access
// assumes requests are single-cycle pulses from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "snv_regs.vh"

module snv_nvm_store #(
	parameter [21:0] LOAD_CYCLES = `SNV_LOAD_CYC,
	parameter [21:0] COMMIT_CYCLES = `SNV_COMMIT_CYC,
	parameter [31:0] IDENTITY = 32'h5A3C_96E1 // arbitrary value
) (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// load request: fetch a word into the read register
	input wire load_req,
	input wire [7:0] load_addr,
	// write request: store a word and start committing it
	input wire write_req,
	input wire [7:0] write_addr,
	input wire [15:0] write_data,
	// results
	output reg [15:0] rd_data_reg,
	output reg busy_reg,
	output wire [1:0] hum_res,
	output wire [1:0] temp_res
);

	reg [15:0] hum_word_reg; // humidity resolution word
	reg [15:0] temp_word_reg; // temperature resolution word
	reg [21:0] cnt_reg; // remaining busy cycles

	assign hum_res = hum_word_reg[`SNV_RES_MSB:`SNV_RES_LSB]; // [R4]
	assign temp_res = temp_word_reg[`SNV_RES_MSB:`SNV_RES_LSB]; // [R4]

	// word storage, read register and busy timer
	always @(posedge ref_clk) begin
		if (reset) begin
			hum_word_reg <= `SNV_RES_WORD_INIT; // [R1]
			temp_word_reg <= `SNV_RES_WORD_INIT; // [R1]
			rd_data_reg <= 16'h0000;
			busy_reg <= 1'b0;
			cnt_reg <= 22'h000000;
		end else begin
			if (write_req) begin
				// whole word stored; commit time follows [R10]
				case (write_addr)
					`SNV_ADDR_HUM_WR: hum_word_reg <= write_data; // [R3]
					`SNV_ADDR_TEMP_WR: temp_word_reg <= write_data; // [R3]
					default: ;
				endcase
				busy_reg <= 1'b1;
				cnt_reg <= COMMIT_CYCLES; // [R10]
			end else if (load_req) begin
				// register select for the next read
				case (load_addr)
					`SNV_ADDR_HUM_RD: rd_data_reg <= hum_word_reg; // [R2]
					`SNV_ADDR_TEMP_RD: rd_data_reg <= temp_word_reg; // [R2]
					`SNV_ADDR_ID_HI: rd_data_reg <= IDENTITY[31:16]; // [R14]
					`SNV_ADDR_ID_LO: rd_data_reg <= IDENTITY[15:0]; // [R14]
					default: rd_data_reg <= 16'h0000;
				endcase
				busy_reg <= 1'b1;
				cnt_reg <= LOAD_CYCLES; // [R9]
			end else if (cnt_reg > 22'h000001) begin
				// counting down the processing time
				cnt_reg <= cnt_reg - 22'h000001;
			end else begin
				// time elapsed: store ready again
				cnt_reg <= 22'h000000;
				busy_reg <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

/* File: core/snv_cfg_target.v */
// two-wire bus target for sensor configuration and measurement output
// assumes scl and sda arrive asynchronously; sda is open drain and is
// pulled low only while sda_oe_n is low
// Functional notes
// [R1] separate resolutions, each defaulting to 14 bits
// [R2] resolution readback at 0x06 and 0x11
// [R3] resolution update at 0x46 and 0x51
// [R4] resolution field lives in bits 11:10
// [R5] codes 00,01,10,11 mean 8,10,12,14 bits
// [R6] controller keeps all other bits unchanged
// [R7] controller reads register before changing it
// [R8] controller writes back the whole word
// [R9] 120 us load time after address write
// [R10] 14 ms commit time after write back
// [R11] temperature change uses 0x11 then 0x51
// [R12] read answers status 0x81 then upper byte
// [R13] 32-bit identity read by same sequence
// [R14] identity upper at 0x1E, lower at 0x1F
// [R15] measurement output is four bytes
// [R16] humidity bits 13:0, temperature bits 15:2
// [R17] committed resolution governs later conversions
// [R18] controller sends 0xA0 0x00 0x00 to enter
// [R19] 120 us needed to process mode entry
// [R20] controller sends 0x80 0x00 0x00 to leave
// [R21] every configuration register is sixteen bits
`timescale 1ns/100ps
`default_nettype none
`include "snv_regs.vh"

module snv_cfg_target #(
	parameter [6:0] TARGET_ADDR = 7'h44,
	parameter [21:0] LOAD_CYCLES = `SNV_LOAD_CYC,
	parameter [21:0] COMMIT_CYCLES = `SNV_COMMIT_CYC,
	parameter [31:0] IDENTITY = 32'h5A3C_96E1 // arbitrary value
) (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// bus pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	// measurement results from the converter
	input wire meas_valid,
	input wire [13:0] meas_hum,
	input wire [13:0] meas_temp,
	// settings for the converter and mode flags
	output reg [1:0] hum_res_code,
	output reg [1:0] temp_res_code,
	output reg prog_mode,
	output reg nvm_busy
);

	// one-hot bus states
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_ADDR = 4'b0010;
	localparam [3:0] ST_WR = 4'b0100;
	localparam [3:0] ST_RD = 4'b1000;

	reg scl_s1_reg, scl_s2_reg, scl_d_reg; // scl synchroniser and delay
	reg sda_s1_reg, sda_s2_reg, sda_d_reg; // sda synchroniser and delay
	reg [3:0] state_reg; // bus state
	reg [3:0] bit_cnt_reg; // 0..7 data bits, 8 byte done, 9 ack slot
	reg [7:0] shift_reg; // received byte
	reg [7:0] tx_reg; // byte being sent
	reg [2:0] byte_idx_reg; // byte count inside transaction
	reg [7:0] cmd_reg; // first written byte
	reg [7:0] arg_hi_reg; // second written byte
	reg [7:0] arg_lo_reg; // third written byte
	reg mack_reg; // controller acknowledged last read byte
	reg fresh_reg; // measurement not yet fetched
	reg [13:0] hum_hold_reg; // latched humidity
	reg [13:0] temp_hold_reg; // latched temperature
	reg load_req_reg; // pulse to store: load
	reg write_req_reg; // pulse to store: write
	reg [7:0] req_addr_reg; // address for either request
	wire [15:0] rd_data; // word loaded in the store
	wire store_busy; // store processing
	wire [1:0] nvm_hum_res; // stored humidity code
	wire [1:0] nvm_temp_res; // stored temperature code
	wire scl_rise, scl_fall, start_det, stop_det; // bus events
	reg [7:0] next_byte; // byte to send next

	assign scl_rise = scl_s2_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s2_reg & scl_d_reg;
	assign start_det = scl_s2_reg & scl_d_reg & ~sda_s2_reg & sda_d_reg;
	assign stop_det = scl_s2_reg & scl_d_reg & sda_s2_reg & ~sda_d_reg;

	// pin synchronisers, second stage feeds an edge delay
	always @(posedge ref_clk) begin
		if (reset) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_d_reg <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_s1_reg <= scl_in;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg <= scl_s2_reg;
			sda_s1_reg <= sda_in;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg <= sda_s2_reg;
		end
	end

	// choose the byte to send by mode and byte index
	always @* begin
		next_byte = 8'hFF;
		if (prog_mode) begin
			case (byte_idx_reg)
				3'h0: next_byte = `SNV_STATUS_OK; // [R12]
				3'h1: next_byte = rd_data[15:8]; // [R12] [R13] [R21]
				3'h2: next_byte = rd_data[7:0]; // [R21]
				default: next_byte = 8'hFF;
			endcase
		end else begin
			// four output bytes: humidity word then temperature word [R15]
			case (byte_idx_reg)
				3'h0: next_byte = {(fresh_reg ? `SNV_MEAS_FRESH :
					`SNV_MEAS_STALE), hum_hold_reg[13:8]}; // [R16]
				3'h1: next_byte = hum_hold_reg[7:0]; // [R16]
				3'h2: next_byte = temp_hold_reg[13:6]; // [R16]
				3'h3: next_byte = {temp_hold_reg[5:0], 2'h0}; // [R16]
				default: next_byte = 8'hFF;
			endcase
		end
	end

	// bus engine, command decode and measurement latch
	always @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			byte_idx_reg <= 3'h0;
			cmd_reg <= 8'h00;
			arg_hi_reg <= 8'h00;
			arg_lo_reg <= 8'h00;
			mack_reg <= 1'b0;
			fresh_reg <= 1'b0;
			hum_hold_reg <= 14'h0000;
			temp_hold_reg <= 14'h0000;
			load_req_reg <= 1'b0;
			write_req_reg <= 1'b0;
			req_addr_reg <= 8'h00;
			prog_mode <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
		end else begin
			load_req_reg <= 1'b0;
			write_req_reg <= 1'b0;
			// new sample latched; fetch clears, but a new sample wins
			if (meas_valid) begin
				hum_hold_reg <= meas_hum;
				temp_hold_reg <= meas_temp;
				fresh_reg <= 1'b1;
			end else if (state_reg == ST_RD && scl_fall &&
				bit_cnt_reg == 4'h8 && byte_idx_reg == 3'h0 && !prog_mode) begin
				fresh_reg <= 1'b0;
			end
			if (start_det) begin
				// start or repeated start
				state_reg <= ST_ADDR;
				bit_cnt_reg <= 4'h0;
				byte_idx_reg <= 3'h0;
				sda_oe_n <= 1'b1;
			end else if (stop_det) begin
				// stop: act on a complete three-byte write
				if (state_reg == ST_WR && byte_idx_reg == 3'h3) begin
					if (cmd_reg == `SNV_CMD_PROG_ENTER) begin
						prog_mode <= 1'b1; // [R18]
						load_req_reg <= 1'b1; // [R19]
						req_addr_reg <= 8'h00;
					end else if (cmd_reg == `SNV_CMD_PROG_LEAVE) begin
						prog_mode <= 1'b0; // [R20]
					end else if (prog_mode && (cmd_reg == `SNV_ADDR_HUM_WR ||
						cmd_reg == `SNV_ADDR_TEMP_WR)) begin
						write_req_reg <= 1'b1; // [R3] [R8] [R11]
						req_addr_reg <= cmd_reg;
					end else if (prog_mode) begin
						load_req_reg <= 1'b1; // [R9] [R7] [R13]
						req_addr_reg <= cmd_reg;
					end
				end
				state_reg <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else if (state_reg != ST_IDLE && scl_rise) begin
				// sample data bits, or the controller's ack after a sent byte
				if (bit_cnt_reg < 4'h8) begin
					shift_reg <= {shift_reg[6:0], sda_s2_reg};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else if (bit_cnt_reg == 4'h9) begin
					mack_reg <= ~sda_s2_reg;
				end
			end else if (state_reg != ST_IDLE && scl_fall) begin
				if (bit_cnt_reg == 4'h8) begin
					bit_cnt_reg <= 4'h9;
					if (state_reg == ST_RD) begin
						// byte sent: release for the ack, point at next byte
						sda_oe_n <= 1'b1;
						if (byte_idx_reg != 3'h7) begin
							byte_idx_reg <= byte_idx_reg + 3'h1;
						end
					end else if (state_reg == ST_ADDR) begin
						// ack own address unless the store is busy
						if (shift_reg[7:1] == TARGET_ADDR && !store_busy &&
							!load_req_reg && !write_req_reg) begin
							sda_oe_n <= 1'b0; // [R9] [R10] [R19]
						end else begin
							state_reg <= ST_IDLE;
						end
					end else begin
						// write data byte: keep the first three
						case (byte_idx_reg)
							3'h0: cmd_reg <= shift_reg;
							3'h1: arg_hi_reg <= shift_reg;
							3'h2: arg_lo_reg <= shift_reg;
							default: ;
						endcase
						if (byte_idx_reg != 3'h7) begin
							byte_idx_reg <= byte_idx_reg + 3'h1;
						end
						sda_oe_n <= 1'b0;
					end
				end else if (bit_cnt_reg == 4'h9) begin
					// end of ack slot
					bit_cnt_reg <= 4'h0;
					if (state_reg == ST_ADDR && shift_reg[0]) begin
						state_reg <= ST_RD;
						tx_reg <= next_byte;
						sda_oe_n <= next_byte[7];
					end else if (state_reg == ST_ADDR) begin
						state_reg <= ST_WR;
						sda_oe_n <= 1'b1;
					end else if (state_reg == ST_RD && mack_reg) begin
						tx_reg <= next_byte;
						sda_oe_n <= next_byte[7];
					end else if (state_reg == ST_RD) begin
						state_reg <= ST_IDLE; // controller ended the read
						sda_oe_n <= 1'b1;
					end else begin
						sda_oe_n <= 1'b1;
					end
				end else if (state_reg == ST_RD) begin
					// shift out the remaining bits, msb first
					sda_oe_n <= tx_reg[3'h7 - bit_cnt_reg[2:0]];
				end
			end
		end
	end

	// converter settings follow the store outside programming mode
	always @(posedge ref_clk) begin
		if (reset) begin
			hum_res_code <= `SNV_RES_14BIT; // [R1]
			temp_res_code <= `SNV_RES_14BIT; // [R1]
			nvm_busy <= 1'b0;
		end else begin
			nvm_busy <= store_busy;
			if (!prog_mode) begin
				hum_res_code <= nvm_hum_res; // [R17] [R5]
				temp_res_code <= nvm_temp_res; // [R17] [R5]
			end
		end
	end

	// configuration word store
	snv_nvm_store #(
		.LOAD_CYCLES(LOAD_CYCLES),
		.COMMIT_CYCLES(COMMIT_CYCLES),
		.IDENTITY(IDENTITY)
	) u_store (
		.ref_clk(ref_clk),
		.reset(reset),
		.load_req(load_req_reg),
		.load_addr(req_addr_reg),
		.write_req(write_req_reg),
		.write_addr(req_addr_reg),
		.write_data({arg_hi_reg, arg_lo_reg}),
		.rd_data_reg(rd_data),
		.busy_reg(store_busy),
		.hum_res(nvm_hum_res),
		.temp_res(nvm_temp_res)
	);

endmodule
`default_nettype wire

/* File: test/snv_monitor.sv */
// port assertions for the sensor configuration target
// assumes one ref_clk domain and a synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module snv_monitor #(
	parameter [21:0] LOAD_CYCLES = 22'h32,
	parameter [21:0] COMMIT_CYCLES = 22'h190
) (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// bus pins
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe_n,
	// settings and flags
	input wire [1:0] hum_res_code,
	input wire [1:0] temp_res_code,
	input wire prog_mode,
	input wire nvm_busy
);
	localparam int LD = LOAD_CYCLES;
	localparam int CM = COMMIT_CYCLES;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// length of the current busy stretch
	reg [21:0] run_reg;
	always @(posedge ref_clk) begin
		if (reset || !nvm_busy)
			run_reg <= 22'h0;
		else
			run_reg <= run_reg + 22'h1;
	end
	// mode entry then the load timer
	sequence s_enter;
		$rose(prog_mode);
	endsequence
	sequence s_load;
		##[0:3] nvm_busy;
	endsequence
	a_reset_values: assert property ($fell(reset) |-> sda_oe_n &&
		!prog_mode && !nvm_busy && hum_res_code == 2'h3 &&
		temp_res_code == 2'h3) else $error("bad values after reset");
	a_entry_busy: assert property (s_enter |-> s_load)
		else $error("no busy after mode entry");
	a_busy_length: assert property ($fell(nvm_busy) |->
		(run_reg >= LD - 2 && run_reg <= LD + 2) ||
		(run_reg >= CM - 2 && run_reg <= CM + 2))
		else $error("busy stretch of wrong length");
	a_busy_silent: assert property (nvm_busy |-> sda_oe_n)
		else $error("answer given while busy");
	a_codes_hold: assert property (prog_mode && $past(prog_mode) |->
		$stable(hum_res_code) && $stable(temp_res_code))
		else $error("settings moved in programming mode");
	a_codes_normal: assert property ($changed(hum_res_code) ||
		$changed(temp_res_code) |-> !prog_mode)
		else $error("settings changed in programming mode");
	a_bit_change: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data moved while clock high");
	a_pull_only: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_ack_length: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
		else $error("driven bit too short");
endmodule
bind snv_cfg_target snv_monitor #(.LOAD_CYCLES(LOAD_CYCLES),
	.COMMIT_CYCLES(COMMIT_CYCLES)) u_mon (.ref_clk(ref_clk),
	.reset(reset), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .hum_res_code(hum_res_code),
	.temp_res_code(temp_res_code), .prog_mode(prog_mode),
	.nvm_busy(nvm_busy));
`default_nettype wire

/* File: test/snv_host.sv */
// two-wire bus controller model facing the configuration target
// assumes sda_line is the wired-and level with a pull-up
`timescale 1ns/100ps
`default_nettype none
module snv_host #(
	parameter [6:0] ADDR = 7'h44,
	parameter int LOAD = 50,
	parameter int COMMIT = 400
) (
	// clock and resolved data line
	input wire logic ref_clk,
	input wire logic sda_line,
	// lines driven by the controller, 1 = released
	output logic scl,
	output logic sda
);
	// idle bus, clock stands high between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// wait whole reference cycles
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// one bit: data moved in clock low, sampled mid clock high
	task automatic bit_x(input logic b, output logic r);
		w(2);
		sda <= b;
		w(6);
		scl <= 1'b1;
		w(4);
		r = sda_line;
		w(4);
		scl <= 1'b0;
	endtask
	// send a byte, ok when the target pulls the ack low
	task automatic put(input logic [7:0] d, output logic ok);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ok = !r;
	endtask
	// fetch a byte, nack on the last one
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
	// three byte write; ok is the address ack
	task automatic wr3(input logic [7:0] a, b, c, output logic ok);
		logic k;
		w(8);
		sda <= 1'b0;
		w(8);
		scl <= 1'b0;
		put({ADDR, 1'b0}, ok);
		put(a, k);
		put(b, k);
		put(c, k);
		w(2);
		sda <= 1'b0;
		w(6);
		scl <= 1'b1;
		w(8);
		sda <= 1'b1;
	endtask
	// read n bytes into v, first byte highest
	task automatic rd(input int n, output logic ok, output logic [31:0] v);
		logic [7:0] d;
		w(8);
		sda <= 1'b0;
		w(8);
		scl <= 1'b0;
		put({ADDR, 1'b1}, ok);
		v = 32'h0;
		for (int i = 0; i < n; i++) begin
			get(i == n - 1, d);
			v = {v[23:0], d};
		end
		w(2);
		sda <= 1'b0;
		w(6);
		scl <= 1'b1;
		w(8);
		sda <= 1'b1;
	endtask
	// fetch, change the field only, write the whole word back
	task automatic rmw(input logic [7:0] ra, wa, input logic [1:0] c,
		output logic [15:0] nw);
		logic ok;
		logic [31:0] v;
		wr3(ra, 8'h00, 8'h00, ok);
		w(LOAD + 8);
		rd(3, ok, v);
		nw = v[15:0];
		nw[11:10] = c;
		wr3(wa, nw[15:8], nw[7:0], ok);
	endtask
endmodule
`default_nettype wire

/* File: test/tb_snv_cfg_target.sv */
// self-checking bench for the sensor configuration target
// assumes the controller model and the port monitor compile first
`timescale 1ns/100ps
`default_nettype none
module tb_snv_cfg_target;
	localparam int LOAD = 50;
	localparam int COMMIT = 400;
	localparam [31:0] ID = 32'hC3A5_0F96; // arbitrary value
	// design inputs
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic meas_valid = 1'b0;
	logic [13:0] meas_hum = 14'h0;
	logic [13:0] meas_temp = 14'h0;
	// pins and outputs
	wire scl, sda_host, sda_out, sda_oe_n, prog_mode, nvm_busy;
	wire [1:0] hum_res_code, temp_res_code;
	// wired-and data line with pull-up
	wire sda_line = sda_host & (sda_oe_n | sda_out);
	// model words and counters
	logic [15:0] hum_w = 16'h0C00;
	logic [15:0] temp_w = 16'h0C00;
	int errors = 0;
	int compares = 0;
	snv_cfg_target #(.LOAD_CYCLES(22'(LOAD)), .COMMIT_CYCLES(22'(COMMIT)),
		.IDENTITY(ID)) dut (.ref_clk(ref_clk), .reset(reset),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .meas_valid(meas_valid),
		.meas_hum(meas_hum), .meas_temp(meas_temp),
		.hum_res_code(hum_res_code), .temp_res_code(temp_res_code),
		.prog_mode(prog_mode), .nvm_busy(nvm_busy));
	snv_host #(.ADDR(7'h44), .LOAD(LOAD), .COMMIT(COMMIT)) host (
		.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda(sda_host));
	// 200 MHz clock
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// expected word at a configuration address
	function automatic logic [15:0] exp_word(input logic [7:0] a);
		case (a)
			8'h06: exp_word = hum_w;
			8'h11: exp_word = temp_w;
			8'h1E: exp_word = ID[31:16];
			8'h1F: exp_word = ID[15:0];
			default: exp_word = 16'h0000;
		endcase
	endfunction
	// compare and count
	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// verdict and end of run
	task automatic summarize;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		errors++;
		summarize;
	end
	// main sequence
	initial begin
		logic ok;
		logic [31:0] v;
		logic [15:0] nw;
		logic [1:0] hc, tc;
		logic [7:0] regs [5];
		void'($urandom(32'h06f30bf3));
		regs = '{8'h06, 8'h11, 8'h1E, 8'h1F, 8'h20};
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		host.w(4);
		chk("hum_res", 32'h3, hum_res_code);
		chk("temp_res", 32'h3, temp_res_code);
		// fresh then stale measurement fetch
		meas_hum <= 14'($urandom);
		meas_temp <= 14'($urandom);
		meas_valid <= 1'b1;
		host.w(1);
		meas_valid <= 1'b0;
		host.rd(4, ok, v);
		chk("meas", {2'h0, meas_hum, meas_temp, 2'h0}, v);
		host.rd(4, ok, v);
		chk("stale", {2'h1, meas_hum, meas_temp, 2'h0}, v);
		// programming mode entry
		host.wr3(8'hA0, 8'h00, 8'h00, ok);
		host.w(8);
		chk("prog", 32'h1, prog_mode);
		host.w(LOAD + 8);
		// every readable word plus an unknown address
		for (int i = 0; i < 5; i++) begin
			host.wr3(regs[i], 8'h00, 8'h00, ok);
			host.w(LOAD + 8);
			host.rd(3, ok, v);
			chk("word", {8'h81, exp_word(regs[i])}, v);
		end
		// every code on the humidity field, random codes on the temperature field, whole words written back
		for (int c = 0; c < 4; c++) begin
			hc = 2'(c) ^ 2'h1;
			tc = 2'(c) ^ 2'(3 & $urandom);
			host.rmw(8'h06, 8'h46, hc, nw);
			chk("hum_word", {hum_w[15:12], hc, hum_w[9:0]}, nw);
			hum_w[11:10] = hc;
			host.w(COMMIT + 8);
			host.rmw(8'h11, 8'h51, tc, nw);
			chk("temp_word", {temp_w[15:12], tc, temp_w[9:0]}, nw);
			temp_w[11:10] = tc;
			if (c == 3) begin
				host.rd(1, ok, v);
				chk("busy_nack", 32'h0, ok);
			end
			host.w(COMMIT + 8);
		end
		// committed words read back through the read addresses
		for (int i = 0; i < 2; i++) begin
			host.wr3(regs[i], 8'h00, 8'h00, ok);
			host.w(LOAD + 8);
			host.rd(3, ok, v);
			chk("readback", {8'h81, exp_word(regs[i])}, v);
		end
		// leave and take up the committed settings
		host.wr3(8'h80, 8'h00, 8'h00, ok);
		host.w(8);
		chk("prog", 32'h0, prog_mode);
		chk("hum_res", hum_w[11:10], hum_res_code);
		chk("temp_res", temp_w[11:10], temp_res_code);
		summarize;
	end
endmodule
`default_nettype wire
